/* core/spimsp_pkg.sv */
// Package: register map, field positions, reset values, transfer length and states of the serial port
package spimsp_pkg;
	// Printed offsets are word indexes; byte address is four times the index
	localparam logic [7:0] IDX_DATA   = 8'h31;
	localparam logic [7:0] IDX_CTRL   = 8'h32;
	localparam logic [7:0] IDX_CSR    = 8'h33;
	localparam logic [7:0] IDX_SYS    = 8'h34;
	localparam logic [9:0] ADDR_DATA  = {IDX_DATA, 2'b00};
	localparam logic [9:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
	localparam logic [9:0] ADDR_CSR   = {IDX_CSR, 2'b00};
	localparam logic [9:0] ADDR_SYS   = {IDX_SYS, 2'b00};
	// Control register fields
	localparam int CR_IRQ_EN  = 7;
	localparam int CR_PE      = 6;
	localparam int CR_DIV2    = 5;
	localparam int CR_MASTER_SELECT    = 4;
	localparam int CR_CLOCK_IDLE_POLARITY    = 3;
	localparam int CR_CLOCK_CAPTURE_PHASE    = 2;
	// Control/status register fields
	localparam int CS_DONE    = 7;
	localparam int CS_WRITE_COLLISION_FLAG    = 6;
	localparam int CS_OVR     = 5;
	localparam int CS_MODE_FAULT_FLAG    = 4;
	localparam int CS_OD      = 2;
	localparam int CS_SSM     = 1;
	localparam int CS_SSI     = 0;
	// System register fields: halt request and condition-code mask
	localparam int SY_HALT    = 0;
	localparam int SY_CCMASK  = 1;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] CSR_RESET  = 3'h0;
	localparam logic [3:0] BITS_PER_XFER = 4'h8;
	typedef enum logic [1:0] {SPIMSP_IDLE, SPIMSP_SHIFT, SPIMSP_DONE} spimsp_state_t;
endpackage

/* core/spimsp_top.sv */
// Serial peripheral port: APB registers, master/slave byte shifter, flags and halt wake-up
// Function
// R1: As slave, a finished transfer wakes the chip from halt; byte stays readable.
// R2: Several transfers during halt before flag clear set the overrun flag.
// R3: Halt wake-up only if internal select was low on entering halt.
// R4: Remote master must hold the select pin low when the slave halts.
// R5: Leaving slave mode restores normal state at once; else next transfer does.
// R6: All three events share one request, gated by enable and CPU mask.
// R7: Enable bit set requests on any flagged event; cleared inhibits it.
// R8: Peripheral enable cleared by reset and master select fault; gates pins.
// R9: Master select cleared on fault; master drives clock and swaps data pins.
// R10: Master clock is pclk over 4..128; div2 bit low adds halving. The code halves with the div2 bit high instead.
// R11: Polarity sets clock idle level in both modes; disable before changing.
// R12: Phase selects first or second clock edge as first capture edge.
// R13: Remote party uses identical polarity and phase settings.
// R14: Done flag set at byte end; cleared by status access then data access.
// R15: While done flag set, data writes ignored until status register read.
// R16: Data write during transfer sets write collision; no interrupt from it.
// R17: New byte while done set sets overrun; status read clears it.
// R18: Select low in master mode sets mode fault; status read, control write clear.
// R19: Output disable stops the active data output; else follows peripheral enable.
// R20: Software management takes select from software level; else from pin.
// R21: Data write loads the shifter; in master mode it starts a byte.
// R22: Received byte copied to buffer at byte end; reads return the buffer.
// R23: On overrun the buffer keeps the first byte; later bytes are dropped.
// R24: Mode fault blocks setting enable and master bits except in clear sequence.
// R25: Colliding write is discarded and the transfer continues.
// R26: Eight bits, most significant first, both directions at once.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module spimsp_top
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Serial pins
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	input  wire logic        select_n_in,
	// System
	output logic             irq,
	output logic             wake
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                ctrl;
		logic                      done;
		logic                      write_collision_flag;
		logic                      overrun_flag;
		logic                      mode_fault_flag;
		logic [2:0]                csr_sw;
		logic [1:0]                sys;
		logic [7:0]                shreg;
		logic [7:0]                rxbuf;
		logic [3:0]                bitcnt;
		logic [6:0]                divcnt;
		logic                      sck_lvl;
		logic                      edge_odd;
		logic [7:0]                rxsh;
		logic [3:0]                rxcnt;
		logic                      rxrdy;
		logic [2:0]                cap_pipe;
		logic [4:0]                edgecnt;
		spimsp_pkg::spimsp_state_t st;
		logic                      csr_seen;
		logic                      mode_fault_flag_seen;
		logic                      write_collision_flag_seen;
		logic                      halted;
		logic                      halt_armed;
		logic                      halt_stale;
		logic [2:0]                sck_sync;
		logic [1:0]                ss_sync;
		logic [1:0]                mosi_sync;
		logic [1:0]                miso_sync;
		logic                      pready;
		logic [31:0]               prdata;
		logic                      pslverr;
		logic                      sck_out;
		logic                      sck_oe_n;
		logic                      mosi_out;
		logic                      mosi_oe_n;
		logic                      miso_out;
		logic                      miso_oe_n;
		logic                      irq;
		logic                      wake;
	} spimsp_regs_t;

	spimsp_regs_t r;
	spimsp_regs_t next_r;

	// ------------------------------------------------------------
	// Combinational next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic       acc;
		logic       wr;
		logic       rd;
		logic [9:0] a;
		logic       master;
		logic       ss_int;
		logic       enable;
		logic       sclk_s;
		logic       sclk_p;
		logic       lead;
		logic       in_bit;
		logic       cap;
		logic       shf;
		logic       fin;
		logic [6:0] half;
		logic [7:0] wctrl;
		logic       rcap;
		logic       fault;
		next_r = r;
		acc    = psel && penable && !r.pready;
		wr     = acc && pwrite;
		rd     = acc && !pwrite;
		a      = paddr[9:0];
		master = r.ctrl[spimsp_pkg::CR_MASTER_SELECT];
		enable = r.ctrl[spimsp_pkg::CR_PE];
		cap    = 1'b0;
		shf    = 1'b0;
		fin    = 1'b0;
		wctrl  = pwdata[7:0];
		rcap   = 1'b0;
		sclk_s = r.sck_sync[1];
		sclk_p = r.sck_sync[2];
		lead   = (sclk_p == r.ctrl[spimsp_pkg::CR_CLOCK_IDLE_POLARITY]);
		fault  = master && !r.csr_sw[spimsp_pkg::CS_SSM] && !r.ss_sync[1];
		// Pin synchronisers; only the last stage is read, except the clock, whose last two stages are read
		next_r.sck_sync  = {r.sck_sync[1:0], sck_in};
		next_r.ss_sync   = {r.ss_sync[0], select_n_in};
		next_r.mosi_sync = {r.mosi_sync[0], mosi_in};
		next_r.miso_sync = {r.miso_sync[0], miso_in};
		ss_int = r.csr_sw[spimsp_pkg::CS_SSM] ? r.csr_sw[spimsp_pkg::CS_SSI]
			: r.ss_sync[1]; // [R20]
		in_bit = master ? r.miso_sync[1] : r.mosi_sync[1];
		// R10: half period = 2^(rate) scaled; /4 is two cycles per half
		unique case ({r.ctrl[spimsp_pkg::CR_DIV2], r.ctrl[1:0]})
			3'b100:  half = 7'h02; // [R10]
			3'b000:  half = 7'h04;
			3'b001:  half = 7'h08;
			3'b110:  half = 7'h10;
			3'b010:  half = 7'h20;
			3'b011:  half = 7'h40;
			default: half = 7'h04;
		endcase
		// ------------------------------------------------------------
		// Shift engine
		// ------------------------------------------------------------
		if (master && enable && r.st == spimsp_pkg::SPIMSP_SHIFT
			&& r.edgecnt != {spimsp_pkg::BITS_PER_XFER, 1'b0})
		begin
			if (r.divcnt == half - 7'h01)
			begin
				next_r.divcnt  = 7'h00;
				next_r.edgecnt = r.edgecnt + 5'h01;
				next_r.sck_lvl = !r.sck_lvl;
				next_r.edge_odd = !r.edge_odd;
				// Leading edge captures when phase is 0, trailing when 1 [R12]
				if (r.edge_odd == r.ctrl[spimsp_pkg::CR_CLOCK_CAPTURE_PHASE])
					cap = 1'b1;
				else
					shf = 1'b1;
			end
			else
				next_r.divcnt = r.divcnt + 7'h01;
		end
		else if (!master && enable && !ss_int)
		begin
			if (sclk_s != sclk_p)
			begin
				if (lead != r.ctrl[spimsp_pkg::CR_CLOCK_CAPTURE_PHASE])
					cap = 1'b1; // [R12]
				else
					shf = 1'b1;
				// Only a leading edge opens a byte, never the trailing edge of the last one
				if (r.st == spimsp_pkg::SPIMSP_IDLE && lead)
					next_r.st = spimsp_pkg::SPIMSP_SHIFT;
			end
		end
		if (!master || r.st == spimsp_pkg::SPIMSP_IDLE)
		begin
			next_r.sck_lvl  = r.ctrl[spimsp_pkg::CR_CLOCK_IDLE_POLARITY]; // [R11]
			next_r.edge_odd = 1'b0;
			next_r.divcnt   = 7'h00;
			next_r.edgecnt  = 5'h00;
		end
		// Master capture waits out the clock output flop and the input synchroniser
		next_r.cap_pipe = {r.cap_pipe[1:0], cap && master};
		rcap = master ? r.cap_pipe[2] : cap;
		if (cap)
			next_r.bitcnt = r.bitcnt + 4'h1;
		// With phase 1 the first edge launches the bit already on the line
		if (shf && (!r.ctrl[spimsp_pkg::CR_CLOCK_CAPTURE_PHASE] || r.bitcnt != 4'h0))
			next_r.shreg = {r.shreg[6:0], 1'b0}; // [R26]
		if (rcap)
		begin
			next_r.rxsh  = {r.rxsh[6:0], in_bit}; // [R26]
			next_r.rxcnt = r.rxcnt + 4'h1;
			if (r.rxcnt == spimsp_pkg::BITS_PER_XFER - 4'h1)
			begin
				next_r.rxcnt = 4'h0;
				next_r.rxrdy = 1'b1;
			end
		end
		// A master also waits for its last clock edge
		fin = r.rxrdy && (!master || r.edgecnt == {spimsp_pkg::BITS_PER_XFER, 1'b0});
		if (fin)
		begin
			next_r.bitcnt = 4'h0;
			next_r.rxrdy  = 1'b0;
			next_r.st = spimsp_pkg::SPIMSP_DONE;
		end
		if (r.st == spimsp_pkg::SPIMSP_DONE)
		begin
			// Phase 0 finishes its last shift here, then the byte is complete
			next_r.st = spimsp_pkg::SPIMSP_IDLE;
			if (master)
				next_r.sck_lvl = r.ctrl[spimsp_pkg::CR_CLOCK_IDLE_POLARITY];
			begin
				logic [7:0] rx;
				rx = r.rxsh;
				next_r.shreg = rx;
				if (r.done)
					next_r.overrun_flag = 1'b1; // [R17] [R2]
				else
					next_r.rxbuf = rx; // [R22] [R23]
				next_r.done = 1'b1; // [R14]
				if (r.halted && !r.halt_stale && r.halt_armed && !master)
					next_r.wake = 1'b1; // [R1] [R3]
			end
		end
		// ------------------------------------------------------------
		// Mode fault
		// ------------------------------------------------------------
		if (fault)
		begin
			next_r.mode_fault_flag = 1'b1; // [R18]
			next_r.rxcnt = 4'h0;
			next_r.rxrdy = 1'b0;
			next_r.ctrl[spimsp_pkg::CR_PE]   = 1'b0; // [R8]
			next_r.ctrl[spimsp_pkg::CR_MASTER_SELECT] = 1'b0; // [R9]
			next_r.st = spimsp_pkg::SPIMSP_IDLE;
			next_r.bitcnt = 4'h0;
		end
		// ------------------------------------------------------------
		// APB access
		// ------------------------------------------------------------
		next_r.pready  = acc;
		next_r.pslverr = 1'b0;
		if (rd)
		begin
			next_r.prdata = 32'h0000_0000;
			unique case (a)
				spimsp_pkg::ADDR_DATA: next_r.prdata[7:0] = r.rxbuf; // [R22]
				spimsp_pkg::ADDR_CTRL: next_r.prdata[7:0] = r.ctrl;
				spimsp_pkg::ADDR_CSR:  next_r.prdata[7:0] =
					{r.done, r.write_collision_flag, r.overrun_flag, r.mode_fault_flag, 1'b0, r.csr_sw};
				spimsp_pkg::ADDR_SYS:  next_r.prdata[7:0] = {6'h00, r.sys};
				default:               next_r.pslverr = 1'b1;
			endcase
		end
		if (wr && !(a inside {spimsp_pkg::ADDR_DATA, spimsp_pkg::ADDR_CTRL,
			spimsp_pkg::ADDR_CSR, spimsp_pkg::ADDR_SYS}))
			next_r.pslverr = 1'b1;
		if (acc && a == spimsp_pkg::ADDR_CSR)
		begin
			next_r.csr_seen  = r.done;
			next_r.write_collision_flag_seen = r.write_collision_flag;
			if (rd)
			begin
				next_r.overrun_flag = r.st == spimsp_pkg::SPIMSP_DONE && r.done; // [R17]
				next_r.mode_fault_flag_seen = r.mode_fault_flag;
			end
			if (wr)
				next_r.csr_sw = pwdata[2:0];
		end
		if (acc && a == spimsp_pkg::ADDR_DATA)
		begin
			if (r.csr_seen && r.st != spimsp_pkg::SPIMSP_DONE)
				next_r.done = 1'b0; // [R14]
			next_r.csr_seen = 1'b0;
			if (r.write_collision_flag_seen)
				next_r.write_collision_flag = 1'b0;
			next_r.write_collision_flag_seen = 1'b0;
			if (wr && !(r.done && !r.csr_seen)) // [R15]
			begin
				if (r.st != spimsp_pkg::SPIMSP_IDLE || (!master && !ss_int && r.bitcnt != 4'h0))
					next_r.write_collision_flag = 1'b1; // [R16] [R25]
				else
				begin
					next_r.shreg = pwdata[7:0]; // [R21]
					next_r.bitcnt = 4'h0;
					next_r.rxcnt = 4'h0;
					next_r.rxrdy = 1'b0;
					if (master && enable)
						next_r.st = spimsp_pkg::SPIMSP_SHIFT; // [R21]
				end
			end
		end
		if (wr && a == spimsp_pkg::ADDR_CTRL)
		begin
			if (r.mode_fault_flag && !r.mode_fault_flag_seen)
			begin
				wctrl[spimsp_pkg::CR_PE]   = 1'b0; // [R24]
				wctrl[spimsp_pkg::CR_MASTER_SELECT] = 1'b0;
			end
			// A fault arriving with the clearing write keeps the flag set
			if (r.mode_fault_flag_seen && !fault)
				next_r.mode_fault_flag = 1'b0; // [R18]
			next_r.mode_fault_flag_seen = 1'b0;
			next_r.ctrl = wctrl;
			if (!wctrl[spimsp_pkg::CR_MASTER_SELECT])
				next_r.halt_stale = 1'b0;
			if (wctrl[spimsp_pkg::CR_MASTER_SELECT])
				next_r.halt_stale = 1'b0; // [R5]
		end
		if (wr && a == spimsp_pkg::ADDR_SYS)
			next_r.sys = pwdata[1:0];
		// ------------------------------------------------------------
		// Halt and wake-up
		// ------------------------------------------------------------
		if (r.sys[spimsp_pkg::SY_HALT] && !r.halted)
		begin
			next_r.halted = 1'b1;
			next_r.halt_armed = !ss_int && !master; // [R3] [R4]
		end
		if (!r.sys[spimsp_pkg::SY_HALT])
		begin
			if (r.halted && !master)
				next_r.halt_stale = 1'b1; // [R5]
			next_r.halted = 1'b0;
			next_r.wake = 1'b0;
		end
		if (master)
			next_r.halt_stale = 1'b0; // [R5]
		else if (r.st == spimsp_pkg::SPIMSP_DONE && !r.halted)
			next_r.halt_stale = 1'b0; // [R5]
		// ------------------------------------------------------------
		// Pins and interrupt
		// ------------------------------------------------------------
		next_r.irq = r.ctrl[spimsp_pkg::CR_IRQ_EN] && !r.sys[spimsp_pkg::SY_CCMASK]
			&& (r.done || r.mode_fault_flag || r.overrun_flag); // [R6] [R7]
		next_r.sck_out   = r.sck_lvl;
		next_r.sck_oe_n  = !(enable && master); // [R9] [R8]
		next_r.mosi_out  = r.shreg[7]; // [R26]
		next_r.miso_out  = r.shreg[7];
		next_r.mosi_oe_n = !(enable && master && !r.csr_sw[spimsp_pkg::CS_OD]); // [R19]
		next_r.miso_oe_n = !(enable && !master && !ss_int
			&& !r.csr_sw[spimsp_pkg::CS_OD]); // [R19]
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r           <= '0;
			r.ctrl      <= spimsp_pkg::CTRL_RESET; // [R8]
			r.csr_sw    <= spimsp_pkg::CSR_RESET;
			r.st        <= spimsp_pkg::SPIMSP_IDLE;
			r.sck_oe_n  <= 1'b1;
			r.mosi_oe_n <= 1'b1;
			r.miso_oe_n <= 1'b1;
			r.ss_sync   <= 2'b11;
		end
		else
			r <= next_r;
	end

	assign pready    = r.pready;
	assign prdata    = r.prdata;
	assign pslverr   = r.pslverr;
	assign sck_out   = r.sck_out;
	assign sck_oe_n  = r.sck_oe_n;
	assign mosi_out  = r.mosi_out;
	assign mosi_oe_n = r.mosi_oe_n;
	assign miso_out  = r.miso_out;
	assign miso_oe_n = r.miso_oe_n;
	assign irq       = r.irq;
	assign wake      = r.wake;
endmodule

/* testbench/spimsp_properties.sv */
// Checker: port-level properties of the serial port
`timescale 1ns/1ps
module spimsp_properties
(
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Pins
	input wire logic        sck_out,
	input wire logic        sck_oe_n,
	input wire logic        miso_oe_n,
	input wire logic        wake
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// Bus answer, then pin roles
	// ----
	sequence access_s;
		psel && penable && !pready;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	answer_once_a: assert property (access_s |=> answer_s)
		else $error("answer not one cycle after access");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	error_timing_a: assert property (pslverr |-> pready)
		else $error("error without answer");
	master_pins_a: assert property (!sck_oe_n |-> miso_oe_n)
		else $error("master drives its input line");
	slave_pins_a: assert property (!miso_oe_n |-> sck_oe_n)
		else $error("slave drives the clock");
	clock_half_a: assert property (!sck_oe_n && $changed(sck_out) |=> $stable(sck_out))
		else $error("clock half period below two cycles");
	wake_slave_a: assert property ($rose(wake) |-> sck_oe_n)
		else $error("wake raised in master mode");
endmodule
bind spimsp_top spimsp_properties chk_i (.*);

/* testbench/spimsp_remote.sv */
// Partner: remote slave exchanging one byte with the port
`timescale 1ns/1ps
module spimsp_remote
(
	// Link
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_n,
	input  wire logic       clock_idle_polarity,
	input  wire logic       clock_capture_phase,
	output logic            miso,
	// Bench
	input  wire logic       load,
	input  wire logic [7:0] tx,
	output logic      [7:0] rx
);
	logic [7:0] sr = 8'h00;
	int         n = 0;
	initial
	begin
		rx = 8'h00;
	end
	always @(posedge load)
	begin
		sr = tx;
		n = 0;
	end
	// Capture edge follows the same polarity and phase as the port
	always @(sck)
		if (!sel_n && sck == !(clock_idle_polarity ^ clock_capture_phase))
		begin
			rx = {rx[6:0], mosi};
			n = n + 1;
		end
		else if (!sel_n && n > 0)
			sr = {sr[6:0], 1'h0};
	// Deselected line shows the inverse so a stale bit never matches
	assign miso = sel_n ? !sr[7] : sr[7];
endmodule

/* testbench/testbench.sv */
// Testbench: registers, master transfers, faults and halt wake-up of the serial port
`timescale 1ns/1ps
module testbench;
	localparam logic [9:0] A_D = spimsp_pkg::ADDR_DATA;
	localparam logic [9:0] A_C = spimsp_pkg::ADDR_CTRL;
	localparam logic [9:0] A_S = spimsp_pkg::ADDR_CSR;
	localparam logic [9:0] A_Y = spimsp_pkg::ADDR_SYS;
	logic        pclk = 1'h0, presetn = 1'h0;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, irq, wake;
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
	logic        select_n_in = 1'h1, sck_m = 1'h0, mosi_m = 1'h0;
	logic        rsel_n = 1'h1, load = 1'h0, pmiso;
	logic [7:0]  tx = 8'h00, prx, b1, b2;
	logic [1:0]  md = 2'h0;
	logic [2:0]  codes [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
	int          seed = 61, mismatches = 0, check_count = 0;
	wire         sck = sck_oe_n ? sck_m : sck_out;
	wire         mosi = mosi_oe_n ? mosi_m : mosi_out;
	spimsp_top uut (.*, .sck_in(sck), .mosi_in(mosi), .miso_in(pmiso));
	spimsp_remote far_i (.sck(sck), .mosi(mosi), .sel_n(rsel_n), .clock_idle_polarity(md[1]),
		.clock_capture_phase(md[0]), .miso(pmiso), .load(load), .tx(tx), .rx(prx));
	initial
	begin
		forever #5 pclk = ~pclk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic guard(input logic ok);
		if (!ok)
		begin
			mismatches++;
			end_of_test();
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= {22'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'h1 && i < 20);
		guard(i < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	function automatic logic [31:0] half(input logic [2:0] r);
		logic [31:0] d;
		d = r[2] ? 32'h4 : 32'h8;
		d = d << (r[1] ? (r[0] ? 4 : 3) : r[0]);
		return d >> 1;
	endfunction
	task automatic wait_sck(input logic lvl, output int n);
		n = 0;
		while (sck_out === lvl && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		guard(n < 3000);
	endtask
	task automatic xfer(input logic [2:0] rate, input logic [1:0] m, input logic col);
		logic [7:0] b, r;
		int         n;
		b = $random(seed);
		r = $random(seed);
		md <= m;
		tx <= r;
		load <= 1'h1;
		apb(1'h1, A_C, {2'h3, rate[2], 1'h1, m, rate[1:0]});
		load <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("idle level", sck_out, m[1]);
		rsel_n <= 1'h0;
		apb(1'h1, A_D, b);
		wait_sck(m[1], n);
		wait_sck(!m[1], n);
		chk("half period", 32'(n), half(rate));
		if (col)
			apb(1'h1, A_D, ~b);
		n = 0;
		do
		begin
			apb(1'h0, A_S, 8'h00);
			n++;
		end
		while (q[7] !== 1'h1 && n < 500);
		guard(n < 500);
		@(posedge pclk);
		chk("status", q[7:0], {1'h1, col, 6'h03});
		chk("request", irq, 1'h1);
		apb(1'h0, A_D, 8'h00);
		chk("received", q[7:0], r);
		chk("far byte", prx, b);
		apb(1'h0, A_S, 8'h00);
		chk("cleared", q[7:0], 8'h03);
		chk("request off", irq, 1'h0);
		rsel_n <= 1'h1;
	endtask
	// Remote master for slave mode, idle low, capture on rising edge
	task automatic sbyte(input logic [7:0] v);
		for (int k = 7; k >= 0; k--)
		begin
			mosi_m <= v[k];
			repeat (8) @(posedge pclk);
			sck_m <= 1'h1;
			repeat (8) @(posedge pclk);
			sck_m <= 1'h0;
		end
		repeat (8) @(posedge pclk);
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, A_C, 8'h00);
		chk("control reset", q[7:4], 4'h0);
		apb(1'h0, A_S, 8'h00);
		chk("status reset", q[7:0], 8'h00);
		apb(1'h0, 10'h3fc, 8'h00);
		chk("unmapped", e, 1'h1);
		apb(1'h1, A_S, 8'h03);
		for (int i = 0; i < 6; i++)
			xfer(codes[i], i[1:0], i == 5);
		apb(1'h1, A_S, 8'h00);
		apb(1'h1, A_C, 8'h50);
		select_n_in <= 1'h0;
		repeat (6) @(posedge pclk);
		chk("fault pins", sck_oe_n, 1'h1);
		apb(1'h1, A_C, 8'h50);
		apb(1'h0, A_C, 8'h00);
		chk("refused", q[7:0] & 8'h50, 8'h00);
		select_n_in <= 1'h1;
		apb(1'h0, A_S, 8'h00);
		chk("fault flag", q[7:0], 8'h10);
		apb(1'h1, A_C, 8'h50);
		apb(1'h0, A_S, 8'h00);
		chk("fault cleared", q[7:0], 8'h00);
		apb(1'h1, A_S, 8'h07);
		select_n_in <= 1'h0;
		repeat (4) @(posedge pclk);
		chk("out disabled", {mosi_oe_n, sck_oe_n}, 2'h2);
		apb(1'h1, A_S, 8'h03);
		repeat (2) @(posedge pclk);
		chk("out enabled", mosi_oe_n, 1'h0);
		apb(1'h0, A_S, 8'h00);
		chk("no fault", q[7:0], 8'h03);
		apb(1'h1, A_C, 8'hc0);
		apb(1'h1, A_S, 8'h00);
		apb(1'h1, A_Y, 8'h01);
		b1 = $random(seed);
		b2 = $random(seed);
		sbyte(b1);
		sbyte(b2);
		chk("wake", wake, 1'h1);
		apb(1'h1, A_Y, 8'h02);
		repeat (2) @(posedge pclk);
		chk("wake off", wake, 1'h0);
		chk("masked", irq, 1'h0);
		apb(1'h1, A_Y, 8'h00);
		repeat (2) @(posedge pclk);
		chk("unmasked", irq, 1'h1);
		apb(1'h0, A_S, 8'h00);
		chk("overrun", q[7:0], 8'ha0);
		apb(1'h0, A_D, 8'h00);
		chk("kept byte", q[7:0], b1);
		apb(1'h0, A_S, 8'h00);
		chk("flags clear", q[7:0], 8'h00);
		end_of_test();
	end
endmodule
